/* core/rbt_top.sv */
// Registered eight-bit bus transceiver between lines A and B.
// Assumes asynchronous pins, AXI4-Lite control, one clock aclk.
//
// Behaviour
// - B enable low, A enable high: both buses released, capture only.
// - B enable high, A enable low: both buses driven from selected sources.
// - Both enables high: A is input, B driven; select low makes B follow A.
// - Both enables low: B is input, A driven; select low makes A follow B.
// - Source select high routes own register, low routes opposite bus.
// - Each register loads only on a rising edge of its own clock.
// - Without a rising edge a register keeps its contents.
// - Both sides eight lines wide; registers and paths eight bits.
// - Inverting variant drives complement of selected data.
// - A driven from live B; B register edge captures live B value.
// - B driven from B register; A register edge captures it.
// - A driven from A register; B register captures it; both edges exchange.
// - Select of an undriven bus has no effect.
// - A register takes B pins; B register takes A pins.
// - A driven while A enable low; B driven while B enable high.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rbt_top #(
    parameter int LINE_W = rbt_pkg::LINE_W,
    parameter bit INVERT = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rbt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rbt_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [rbt_pkg::DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rbt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rbt_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [LINE_W-1:0] a_side_lines_i,
    output logic [LINE_W-1:0] a_side_lines_o,
    output logic [LINE_W-1:0] a_side_lines_oe,
    input wire logic [LINE_W-1:0] b_side_lines_i,
    output logic [LINE_W-1:0] b_side_lines_o,
    output logic [LINE_W-1:0] b_side_lines_oe,
    input wire logic reg_a_capture_clock,
    input wire logic reg_b_capture_clock
);
    localparam int SW = 2 * LINE_W + 2;

    function automatic logic reg_hit(input logic [rbt_pkg::ADDR_W-1:0] addr,
                                     input logic [rbt_pkg::ADDR_W-1:0] off);
        reg_hit = (addr[rbt_pkg::ADDR_W-1:2] == off[rbt_pkg::ADDR_W-1:2]);
    endfunction

    function automatic logic [LINE_W-1:0] drive_pol(input logic [LINE_W-1:0] d);
        drive_pol = INVERT ? ~d : d;
    endfunction

    logic [rbt_pkg::ADDR_W-1:0] wr_addr, rd_addr;
    logic [rbt_pkg::DATA_W-1:0] wr_data;
    logic [rbt_pkg::DATA_W-1:0] rd_data;
    logic [rbt_pkg::DATA_W/8-1:0] wr_strb;
    logic wr_en;
    logic wr_ok, rd_ok;
    logic [SW-1:0] sync_out;
    logic [rbt_pkg::CTRL_W-1:0] ctrl_ff;
    logic [LINE_W-1:0] a_side_capture_reg;
    logic [LINE_W-1:0] b_side_capture_reg;
    logic [1:0] clk_prev_ff;
    logic loaded_a_ff, loaded_b_ff;
    logic [LINE_W-1:0] a_out_ff, b_out_ff, a_oe_ff, b_oe_ff;
    logic [LINE_W-1:0] nxt_a_out, nxt_b_out;

    rbt_axil #(
        .ADDR_W(rbt_pkg::ADDR_W),
        .DATA_W(rbt_pkg::DATA_W)
    ) u_rbt_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_en(wr_en),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Pins and capture clocks are asynchronous to aclk
    rbt_sync #(
        .WIDTH(SW)
    ) u_rbt_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({reg_b_capture_clock, reg_a_capture_clock, b_side_lines_i, a_side_lines_i}),
        .sync_out(sync_out)
    );

    wire [LINE_W-1:0] a_pin_s = sync_out[LINE_W-1:0];
    wire [LINE_W-1:0] b_pin_s = sync_out[2*LINE_W-1:LINE_W];
    wire [1:0] cap_clk_s = sync_out[SW-1:2*LINE_W];

    // Control fields
    wire b_side_drive_enable = ctrl_ff[rbt_pkg::CTRL_B_DRIVE_POS];
    wire a_side_drive_enable_low = ctrl_ff[rbt_pkg::CTRL_A_DRIVE_N_POS];
    wire a_output_source_select = ctrl_ff[rbt_pkg::CTRL_A_SRC_POS];
    wire b_output_source_select = ctrl_ff[rbt_pkg::CTRL_B_SRC_POS];
    wire rbt_pkg::rbt_mode_t mode = rbt_pkg::rbt_mode_t'({b_side_drive_enable,
                                                          a_side_drive_enable_low});

    // Output enables are independent per side
    wire a_drive = !a_side_drive_enable_low;
    wire b_drive = b_side_drive_enable;

    // Level seen on each set of pins: our own drive when enabled
    wire [LINE_W-1:0] a_eff = a_oe_ff[0] ? a_out_ff : a_pin_s;
    wire [LINE_W-1:0] b_eff = b_oe_ff[0] ? b_out_ff : b_pin_s;

    // Rising edges of the synchronised capture clocks
    wire no_clock_edge_a = !(cap_clk_s[0] && !clk_prev_ff[0]);
    wire no_clock_edge_b = !(cap_clk_s[1] && !clk_prev_ff[1]);
    wire edge_a = !no_clock_edge_a;
    wire edge_b = !no_clock_edge_b;

    // Source muxes; registered output breaks the pin loop
    assign nxt_a_out = drive_pol(a_output_source_select ? a_side_capture_reg : b_eff);
    assign nxt_b_out = drive_pol(b_output_source_select ? b_side_capture_reg : a_eff);

    // Register decode
    assign wr_ok = reg_hit(wr_addr, rbt_pkg::OFF_CTRL);
    wire rd_ctrl = reg_hit(rd_addr, rbt_pkg::OFF_CTRL);
    wire rd_stat = reg_hit(rd_addr, rbt_pkg::OFF_STATUS);
    wire rd_lines = reg_hit(rd_addr, rbt_pkg::OFF_LINES);
    assign rd_ok = rd_ctrl || rd_stat || rd_lines;
    wire [rbt_pkg::DATA_W-1:0] ctrl_word = {{(rbt_pkg::DATA_W - rbt_pkg::CTRL_W){1'b0}},
                                            ctrl_ff};
    wire [rbt_pkg::DATA_W-1:0] stat_word = {{(rbt_pkg::DATA_W - SW - 2){1'b0}},
                                            loaded_b_ff, loaded_a_ff, mode,
                                            b_side_capture_reg, a_side_capture_reg};
    wire [rbt_pkg::DATA_W-1:0] lines_word = {{(rbt_pkg::DATA_W - 2 * LINE_W){1'b0}},
                                             b_eff, a_eff};
    assign rd_data = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : lines_word);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= rbt_pkg::CTRL_RESET;
        end else if (wr_en && wr_ok && wr_strb[0]) begin
            ctrl_ff <= wr_data[rbt_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev_ff <= 2'h0;
            loaded_a_ff <= 1'b0;
            loaded_b_ff <= 1'b0;
        end else begin
            clk_prev_ff <= cap_clk_s;
            loaded_a_ff <= loaded_a_ff || edge_a;
            loaded_b_ff <= loaded_b_ff || edge_b;
        end
    end

    // No reset: contents stay unknown until first capture
    always_ff @(posedge aclk) begin
        if (edge_a) begin
            a_side_capture_reg <= b_eff;
        end
        if (edge_b) begin
            b_side_capture_reg <= a_eff;
        end
    end

    // Select of an undriven side only feeds a disabled output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_out_ff <= '0;
            b_out_ff <= '0;
            a_oe_ff <= '0;
            b_oe_ff <= '0;
        end else begin
            a_out_ff <= nxt_a_out;
            b_out_ff <= nxt_b_out;
            a_oe_ff <= {LINE_W{a_drive}};
            b_oe_ff <= {LINE_W{b_drive}};
        end
    end

    assign a_side_lines_o = a_out_ff;
    assign b_side_lines_o = b_out_ff;
    assign a_side_lines_oe = a_oe_ff;
    assign b_side_lines_oe = b_oe_ff;

    // Checks; outside drivers assumed quiet on driven lines
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_storage_release: assert property (
        (!b_side_drive_enable && a_side_drive_enable_low)
        |=> (a_side_lines_oe == 8'h00 && b_side_lines_oe == 8'h00))
        else $error("storage mode drives a bus");

    a_both_driven: assert property (
        (b_side_drive_enable && !a_side_drive_enable_low)
        |=> (a_side_lines_oe == 8'hFF && b_side_lines_oe == 8'hFF))
        else $error("transfer mode does not drive both buses");

    a_b_follows_a: assert property (
        (mode == rbt_pkg::RBT_A_TO_B && !b_output_source_select)
        |=> (b_side_lines_o == drive_pol($past(a_eff)) && a_side_lines_oe == 8'h00))
        else $error("B bus does not follow A bus");

    a_a_follows_b: assert property (
        (mode == rbt_pkg::RBT_B_TO_A && !a_output_source_select)
        |=> (a_side_lines_o == drive_pol($past(b_eff)) && b_side_lines_oe == 8'h00))
        else $error("A bus does not follow B bus");

    a_a_reg_source: assert property (
        (a_drive && a_output_source_select && loaded_a_ff && no_clock_edge_a)
        |=> (a_side_lines_o == drive_pol(a_side_capture_reg)))
        else $error("A bus not driven from A register");

    a_capture_load: assert property (
        edge_a |=> (a_side_capture_reg == $past(b_eff)))
        else $error("A register missed a capture");

    a_capture_hold: assert property (
        (loaded_b_ff && no_clock_edge_b) |=> $stable(b_side_capture_reg))
        else $error("B register changed without an edge");

    a_reg_exchange: assert property (
        (edge_a && edge_b && mode == rbt_pkg::RBT_TRANSFER && a_output_source_select
         && b_output_source_select && $stable(ctrl_ff))
        |=> (b_side_capture_reg == $past(a_side_lines_o)
             && a_side_capture_reg == $past(b_side_lines_o)))
        else $error("registers did not exchange");

    a_enable_track: assert property (
        ##1 (a_side_lines_oe[0] == !$past(a_side_drive_enable_low)
             && b_side_lines_oe[0] == $past(b_side_drive_enable)))
        else $error("output enable does not track its enable");

    // Register paths need steady CTRL: enables lag it by one edge
    a_b_capture_load: assert property (
        edge_b |=> (b_side_capture_reg == $past(a_eff)))
        else $error("B register missed a capture");

    a_a_capture_hold: assert property (
        (loaded_a_ff && no_clock_edge_a) |=> $stable(a_side_capture_reg))
        else $error("A register changed without an edge");

    a_b_reg_source: assert property (
        (b_drive && b_output_source_select && loaded_b_ff && no_clock_edge_b)
        |=> (b_side_lines_o == drive_pol(b_side_capture_reg)))
        else $error("B bus not driven from B register");

    a_live_b_capture: assert property (
        (a_drive && !a_output_source_select && edge_b && $stable(ctrl_ff))
        |=> (b_side_capture_reg == $past(a_side_lines_o)))
        else $error("B register missed live B data");

    a_reg_to_reg: assert property (
        (b_drive && b_output_source_select && edge_a && $stable(ctrl_ff))
        |=> (a_side_capture_reg == $past(b_side_lines_o)))
        else $error("A register missed B register data");

    a_a_reg_forward: assert property (
        (a_drive && a_output_source_select && edge_b && $stable(ctrl_ff))
        |=> (b_side_capture_reg == $past(a_side_lines_o)))
        else $error("B register missed A register data");

    a_a_loaded_flag: assert property (
        edge_a |=> loaded_a_ff)
        else $error("A loaded flag not set");

    a_b_loaded_flag: assert property (
        edge_b |=> loaded_b_ff)
        else $error("B loaded flag not set");

    a_a_drive_only: assert property (
        (mode == rbt_pkg::RBT_B_TO_A)
        |=> (a_side_lines_oe == '1 && b_side_lines_oe == '0))
        else $error("B-to-A enables wrong");

    a_b_drive_only: assert property (
        (mode == rbt_pkg::RBT_A_TO_B)
        |=> (a_side_lines_oe == '0 && b_side_lines_oe == '1))
        else $error("A-to-B enables wrong");

    a_oe_whole_bus: assert property (
        (a_side_lines_oe == '0 || a_side_lines_oe == '1)
        && (b_side_lines_oe == '0 || b_side_lines_oe == '1))
        else $error("output enables split within a bus");

    a_write_refused: assert property (
        s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
        else $error("write accepted while response pending");

    a_read_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");

    a_bad_write_ignored: assert property (
        (wr_en && !wr_ok) |=> $stable(ctrl_ff))
        else $error("unmapped write changed control");

    a_bad_read_zero: assert property (
        (s_axi_rvalid && s_axi_rresp == rbt_pkg::RESP_SLVERR) |-> (s_axi_rdata == '0))
        else $error("refused read returned data");

    c_storage_capture: cover property (mode == rbt_pkg::RBT_STORAGE && edge_a && edge_b);
    c_exchange: cover property (mode == rbt_pkg::RBT_TRANSFER && edge_a && edge_b);
    c_ctrl_write: cover property (wr_en && wr_ok);
    c_live_a_to_b: cover property (mode == rbt_pkg::RBT_A_TO_B && edge_b);
    c_reg_to_reg: cover property (b_drive && b_output_source_select && edge_a);
endmodule
`default_nettype wire

/* core/rbt_pkg.sv */
// Constants for the registered bus transceiver.
// Assumes AXI4-Lite with 32-bit data and 12-bit byte addresses.
package rbt_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LINE_W = 8;
    localparam int SYNC_STAGES = 2;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_LINES = 12'h008;

    localparam int CTRL_B_DRIVE_POS = 0;
    localparam int CTRL_A_DRIVE_N_POS = 1;
    localparam int CTRL_A_SRC_POS = 2;
    localparam int CTRL_B_SRC_POS = 3;
    localparam int CTRL_W = 4;
    // Storage mode after reset: both buses released
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h2;

    localparam int STAT_REG_A_POS = 0;
    localparam int STAT_REG_B_POS = 8;
    localparam int STAT_MODE_POS = 16;
    localparam int STAT_LOADED_POS = 18;
    localparam int LINES_A_POS = 0;
    localparam int LINES_B_POS = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RBT_B_TO_A = 2'b00,
        RBT_STORAGE = 2'b01,
        RBT_TRANSFER = 2'b10,
        RBT_A_TO_B = 2'b11
    } rbt_mode_t;
endpackage

/* core/rbt_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module rbt_sync #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

/* core/rbt_axil.sv */
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the parent decodes held addresses combinationally.
`timescale 1ns/1ps
`default_nettype none
module rbt_axil #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic [DATA_W/8-1:0] wr_strb,
    output logic wr_en,
    input wire logic wr_ok,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic rd_ok
);
    logic aw_got_ff, w_got_ff, ar_got_ff, wr_en_ff;
    logic awready_ff, wready_ff, arready_ff, bvalid_ff, rvalid_ff;
    logic [ADDR_W-1:0] awaddr_ff, araddr_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;
    logic [DATA_W/8-1:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    wire aw_hs = s_axi_awvalid && awready_ff;
    wire w_hs = s_axi_wvalid && wready_ff;
    wire ar_hs = s_axi_arvalid && arready_ff;
    wire wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    wire rd_fire = ar_got_ff && !rvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            wr_en_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            // Ready drops while a write waits for its response
            awready_ff <= !aw_got_ff && !bvalid_ff && !aw_hs;
            wready_ff <= !w_got_ff && !bvalid_ff && !w_hs;
            wr_en_ff <= wr_fire;
            if (aw_hs) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_got_ff <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'h0;
            araddr_ff <= '0;
            rdata_ff <= '0;
        end else begin
            arready_ff <= !ar_got_ff && !rvalid_ff && !ar_hs;
            if (ar_hs) begin
                ar_got_ff <= 1'b1;
                araddr_ff <= s_axi_araddr;
            end
            if (rd_fire) begin
                ar_got_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_ok ? rd_data : '0;
                rresp_ff <= rd_ok ? 2'h0 : 2'h2;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wr_addr = awaddr_ff;
    assign wr_data = wdata_ff;
    assign wr_strb = wstrb_ff;
    assign wr_en = wr_en_ff;
    assign rd_addr = araddr_ff;
endmodule
`default_nettype wire

/* testbench/rbt_far_end.sv */
// Model of the logic hanging on the A and B lines.
// Assumes the bench says when each side drives and with what value.
`timescale 1ns/1ps
`default_nettype none
module rbt_far_end (
    input wire logic aclk,
    input wire logic [7:0] a_o,
    input wire logic [7:0] a_oe,
    input wire logic [7:0] b_o,
    input wire logic [7:0] b_oe,
    input wire logic a_drv_en,
    input wire logic [7:0] a_drv_val,
    input wire logic b_drv_en,
    input wire logic [7:0] b_drv_val,
    output logic [7:0] a_level,
    output logic [7:0] b_level
);
    logic [7:0] a_last_ff = 8'h00;
    logic [7:0] b_last_ff = 8'h00;
    logic [7:0] a_far;
    logic [7:0] b_far;
    // Far side yields to the device; a floating line toggles, never holds
    assign a_far = (a_drv_en && a_oe == 8'h00) ? a_drv_val : ~a_last_ff;
    assign b_far = (b_drv_en && b_oe == 8'h00) ? b_drv_val : ~b_last_ff;
    assign a_level = (a_oe & a_o) | (~a_oe & a_far);
    assign b_level = (b_oe & b_o) | (~b_oe & b_far);
    always_ff @(posedge aclk) begin
        a_last_ff <= a_level;
        b_last_ff <= b_level;
    end
endmodule
`default_nettype wire

/* testbench/tb_rbt_top.sv */
// Self-checking bench for the transceiver, non-inverting build.
// Assumes the far-end model resolves both line groups.
`timescale 1ns/1ps
`default_nettype none
module tb_rbt_top;
    logic aclk;
    logic aresetn;
    logic [11:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] a_i, a_o, a_oe, b_i, b_o, b_oe;
    logic ck_a, ck_b;
    logic a_drv_en, b_drv_en;
    logic [7:0] a_drv_val, b_drv_val;
    logic [31:0] d;
    logic [1:0] r;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    rbt_top #(.LINE_W(8), .INVERT(1'b0)) u_rbt_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .a_side_lines_i(a_i), .a_side_lines_o(a_o), .a_side_lines_oe(a_oe),
        .b_side_lines_i(b_i), .b_side_lines_o(b_o), .b_side_lines_oe(b_oe),
        .reg_a_capture_clock(ck_a), .reg_b_capture_clock(ck_b)
    );

    rbt_far_end u_rbt_far_end (
        .aclk(aclk), .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe),
        .a_drv_en(a_drv_en), .a_drv_val(a_drv_val), .b_drv_en(b_drv_en),
        .b_drv_val(b_drv_val), .a_level(a_i), .b_level(b_i)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Run is under two hundred cycles; the ceiling only catches a hang
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_p;
        logic w_p;
        logic done;
        aw_p = 1'b1;
        w_p = 1'b1;
        done = 1'b0;
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge aclk);
    endtask

    // Capture clocks held well past the two-cycle synchroniser window
    task automatic pulse(input logic [1:0] which);
        repeat (4) @(posedge aclk);
        ck_a <= which[0];
        ck_b <= which[1];
        repeat (4) @(posedge aclk);
        ck_a <= 1'b0;
        ck_b <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        aresetn = 1'b0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        {awvalid, wvalid, bready, arvalid, rready, ck_a, ck_b} = 7'h00;
        a_drv_en = 1'b1;
        b_drv_en = 1'b1;
        a_drv_val = 8'h5A;
        b_drv_val = 8'hC3;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(rbt_pkg::OFF_CTRL, d, r);
        chk(d, 32'(rbt_pkg::CTRL_RESET));
        chk({a_oe, b_oe}, 32'h0000_0000);
        rd(12'h00C, d, r);
        chk(32'(r), 32'(rbt_pkg::RESP_SLVERR));
        wr(12'h010, 32'h0000_000F, r);
        chk(32'(r), 32'(rbt_pkg::RESP_SLVERR));
        rd(rbt_pkg::OFF_CTRL, d, r);
        chk(d, 32'(rbt_pkg::CTRL_RESET));
        // Storage: both registers load from opposite pins
        pulse(2'b11);
        rd(rbt_pkg::OFF_STATUS, d, r);
        chk(32'(d[19:0]), 32'h000D_5AC3);
        a_drv_val <= 8'h11;
        b_drv_val <= 8'h22;
        pulse(2'b01);
        rd(rbt_pkg::OFF_STATUS, d, r);
        chk(32'(d[15:0]), 32'h0000_5A22);
        // A-to-B with live follow, then register source
        b_drv_en <= 1'b0;
        a_drv_val <= 8'h96;
        wr(rbt_pkg::OFF_CTRL, 32'h0000_0003, r);
        chk(32'(r), 32'(rbt_pkg::RESP_OKAY));
        settle();
        chk({8'h00, b_o, b_oe, a_oe}, 32'h0096_FF00);
        wr(rbt_pkg::OFF_CTRL, 32'h0000_0007, r);
        settle();
        chk({8'h00, b_o, b_oe, a_oe}, 32'h0096_FF00);
        wr(rbt_pkg::OFF_CTRL, 32'h0000_000B, r);
        settle();
        chk(32'(b_o), 32'h0000_005A);
        pulse(2'b01);
        // Through storage so neither side ever fights the device
        wr(rbt_pkg::OFF_CTRL, 32'h0000_0002, r);
        a_drv_en <= 1'b0;
        b_drv_en <= 1'b1;
        b_drv_val <= 8'h3C;
        wr(rbt_pkg::OFF_CTRL, 32'h0000_0000, r);
        settle();
        chk({8'h00, a_o, a_oe, b_oe}, 32'h003C_FF00);
        pulse(2'b10);
        rd(rbt_pkg::OFF_STATUS, d, r);
        chk(32'(d[17:0]), 32'h0000_3C5A);
        // Transfer stored data both ways, then exchange
        b_drv_en <= 1'b0;
        wr(rbt_pkg::OFF_CTRL, 32'h0000_000D, r);
        settle();
        chk({a_o, a_oe, b_o, b_oe}, 32'h5AFF_3CFF);
        pulse(2'b11);
        settle();
        rd(rbt_pkg::OFF_STATUS, d, r);
        chk(32'(d[17:0]), 32'h0002_5A3C);
        rd(rbt_pkg::OFF_LINES, d, r);
        chk(32'(d[15:0]), 32'h0000_5A3C);
        chk({16'h0000, a_o, b_o}, 32'h0000_3C5A);
        close_out();
    end
endmodule
`default_nettype wire
